/* rtl/bltr_params.svh */
// Constants of the block transfer blitter: register indices, fields, resets
// Operation
// - Once started with valid settings, engine stays busy until whole block completes.
// - Completion drives the interrupt pin; host reads cause from interrupt source register.
// - Busy readable at control zero bit 4 and main status bit 3.
// - Code 0000b host write with logic; 0010b memory copy with logic.
// - Codes 0100b host write keyed, 0101b memory copy keyed, no logic.
// - Code 0110b pattern fill with logic; 0111b pattern fill keyed, no logic.
// - Colour expansion codes 1000b, 1001b keyed, 1110b memory, 1111b memory keyed.
// - Code 1010b memory copy blended; 1011b host write blended; no logic.
// - Code 1100b solid fill of destination, no logic function.
// - Logic field bits 7..4 picks one of sixteen bitwise functions of A, B.
// - Remaining codes give NOR, NAND, AND, XOR, XNOR, OR, inverted forms.
// - Source A from host or memory, source B memory, results to memory.
// - In expansion the logic field is the first bit; 8-bit port allows 0..7.
// - Palette of 64 entries by 12 bits, indexed by colour, used in blending.
// - Palette loaded as 128 byte writes in one run; never readable.
// - Upper nibble of each even-numbered palette byte is discarded.
// - Keying skips destination write when source A equals background colour.
// - Solid fill writes foreground colour into every destination pixel.
// - Expansion turns ones into foreground colour, zeros into background colour.
`ifndef BLTR_PARAMS_SVH
`define BLTR_PARAMS_SVH
// Register indices; byte address is four times the index
`define BLTR_IDX_STATUS 8'h01
`define BLTR_IDX_INTSRC 8'h0C
`define BLTR_IDX_CTRL0 8'h90
`define BLTR_IDX_OPLOG 8'h91
`define BLTR_IDX_A_BASE 8'h93
`define BLTR_IDX_A_WIDTH 8'h97
`define BLTR_IDX_B_BASE 8'h9D
`define BLTR_IDX_B_WIDTH 8'hA1
`define BLTR_IDX_D_BASE 8'hA7
`define BLTR_IDX_D_WIDTH 8'hAB
`define BLTR_IDX_WIN_W 8'hB1
`define BLTR_IDX_WIN_H 8'hB2
`define BLTR_IDX_PAL_DATA 8'hB3
`define BLTR_IDX_ALPHA 8'hB4
`define BLTR_IDX_FG 8'hD2
`define BLTR_IDX_BG 8'hD5
// Field positions
`define BLTR_CTRL0_START 7
`define BLTR_CTRL0_BUSY 4
`define BLTR_CTRL0_PALMODE 0
`define BLTR_STATUS_BUSY 3
`define BLTR_INTSRC_DONE 0
// Reset values and sizes
`define BLTR_RST_OPLOG 8'h00
`define BLTR_RST_WIN 12'h001
`define BLTR_RST_ALPHA 5'h10
`define BLTR_PAL_ENTRIES 64
`define BLTR_PAL_BYTES 128
`define BLTR_ALPHA_FULL 6'h10
`endif

/* rtl/bltr_pkg.sv */
// Types of the block transfer blitter
package bltr_pkg;
  typedef enum logic [3:0] {
    BLTR_OP_HOST_LOGIC = 4'h0, BLTR_OP_COPY_LOGIC = 4'h2, BLTR_OP_HOST_KEY = 4'h4,
    BLTR_OP_COPY_KEY = 4'h5, BLTR_OP_PAT_LOGIC = 4'h6, BLTR_OP_PAT_KEY = 4'h7,
    BLTR_OP_HOST_EXP = 4'h8, BLTR_OP_HOST_EXP_KEY = 4'h9, BLTR_OP_COPY_BLEND = 4'hA,
    BLTR_OP_HOST_BLEND = 4'hB, BLTR_OP_FILL = 4'hC, BLTR_OP_COPY_EXP = 4'hE,
    BLTR_OP_COPY_EXP_KEY = 4'hF
  } bltr_op_t;
  typedef struct packed {
    logic host; logic pat; logic fill; logic exp; logic key; logic lfn; logic blend; logic rsv;
  } bltr_flags_t;
  typedef enum {ST_IDLE, ST_GET_A, ST_GET_B, ST_PUT, ST_DONE} bltr_state_t;
endpackage

/* rtl/bltr_pix_combine.sv */
// Pixel combiner: sixteen bitwise logic functions and opacity blend
`include "bltr_params.svh"
module bltr_pix_combine import bltr_pkg::*; (
  input wire logic [3:0] logic_code,
  input wire logic [4:0] alpha,
  input wire logic [23:0] src_a,
  input wire logic [23:0] src_b,
  output logic [23:0] logic_out,
  output logic [23:0] blend_out
);
  logic [5:0] alpha_inv;
  assign alpha_inv = `BLTR_ALPHA_FULL - {1'b0, alpha};
  // Code bit {a,b} is the truth table, so 1100b gives A and 1010b gives B
  for (genvar i = 0; i < 24; i++) begin : g_bit
    assign logic_out[i] = logic_code[{src_a[i], src_b[i]}];
  end
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [13:0] mix;
    assign mix = 14'(src_a[c*8 +: 8] * alpha) + 14'(src_b[c*8 +: 8] * alpha_inv);
    assign blend_out[c*8 +: 8] = mix[11:4];
  end
endmodule // bltr_pix_combine

/* rtl/bltr_palette.sv */
// Write-only colour palette, 64 entries of 12 bits, loaded bytewise
`include "bltr_params.svh"
module bltr_palette import bltr_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic byte_we,
  input wire logic [7:0] byte_data,
  input wire logic [5:0] rd_index,
  output logic [11:0] rd_entry
);
  logic [11:0] mem_q [`BLTR_PAL_ENTRIES];
  logic [6:0] seq_q;
  logic [3:0] hi_q;
  // Even bytes carry the upper nibble of an entry, odd bytes its low byte
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_q <= 7'h00;
      hi_q <= 4'h0;
    end else if (byte_we) begin
      seq_q <= seq_q + 7'h01;
      if (!seq_q[0]) begin
        hi_q <= byte_data[3:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (byte_we && seq_q[0]) begin
      mem_q[seq_q[6:1]] <= {hi_q, byte_data};
    end
  end
  assign rd_entry = mem_q[rd_index];
endmodule // bltr_palette

/* rtl/bltr_engine.sv */
// Block transfer engine with AXI4-Lite register slave
//
// Decided for this implementation: register access over AXI4-Lite.
`include "bltr_params.svh"
module bltr_engine import bltr_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_port_16bit,
  input wire logic [15:0] host_data,
  input wire logic host_valid,
  output logic host_ready,
  output logic [23:0] mem_addr,
  output logic mem_rd,
  input wire logic [23:0] mem_rdata,
  output logic mem_wr,
  output logic [23:0] mem_wdata,
  output logic int_n
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic bltr_flags_t op_flags(input logic [3:0] op);
    bltr_flags_t f;
    f.host = op inside {4'h0, 4'h4, 4'h8, 4'h9, 4'hB};
    f.pat = op inside {4'h6, 4'h7};
    f.fill = (op == BLTR_OP_FILL);
    f.exp = op inside {4'h8, 4'h9, 4'hE, 4'hF};
    f.key = op inside {4'h4, 4'h5, 4'h7, 4'h9, 4'hF};
    f.lfn = op inside {4'h0, 4'h2, 4'h6};
    f.blend = op inside {4'hA, 4'hB};
    f.rsv = op inside {4'h1, 4'h3, 4'hD};
    return f;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, bad_wr_q, int_flag_q;
  logic [7:0] aw_idx_q, oplog_q, ctrl0_q;
  logic [1:0] rresp_q;
  logic [31:0] wdata_q, rdata_q, rd_word, old_word, wr_word;
  logic [3:0] wstrb_q;
  logic [23:0] a_base_q, b_base_q, d_base_q, fg_q, bg_q;
  logic [11:0] a_width_q, b_width_q, d_width_q, win_w_q, win_h_q;
  logic [4:0] alpha_q;
  bltr_state_t state_q;
  logic busy;
  logic wr_fire, start_w, pal_we, rd_fire, rd_mapped, wr_mapped;
  logic [7:0] ar_idx;
  logic [32:0] rd_view, wr_view;

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bad_wr_q ? 2'h2 : 2'h0;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign busy = (state_q != ST_IDLE);
  assign int_n = !int_flag_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign ar_idx = s_axi_araddr[9:2];
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign start_w = wr_fire && aw_idx_q == `BLTR_IDX_CTRL0 && wstrb_q[0] && wdata_q[`BLTR_CTRL0_START] && !busy;
  assign pal_we = wr_fire && aw_idx_q == `BLTR_IDX_PAL_DATA && wstrb_q[0];

  function automatic logic [32:0] reg_view(input logic [7:0] idx);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    unique case (idx)
      `BLTR_IDX_STATUS: v[`BLTR_STATUS_BUSY] = busy;
      `BLTR_IDX_INTSRC: v[`BLTR_INTSRC_DONE] = int_flag_q;
      `BLTR_IDX_CTRL0: v[7:0] = {1'b0, ctrl0_q[6:5], busy, ctrl0_q[3:0]};
      `BLTR_IDX_OPLOG: v[7:0] = oplog_q;
      `BLTR_IDX_A_BASE: v[23:0] = a_base_q;
      `BLTR_IDX_A_WIDTH: v[11:0] = a_width_q;
      `BLTR_IDX_B_BASE: v[23:0] = b_base_q;
      `BLTR_IDX_B_WIDTH: v[11:0] = b_width_q;
      `BLTR_IDX_D_BASE: v[23:0] = d_base_q;
      `BLTR_IDX_D_WIDTH: v[11:0] = d_width_q;
      `BLTR_IDX_WIN_W: v[11:0] = win_w_q;
      `BLTR_IDX_WIN_H: v[11:0] = win_h_q;
      `BLTR_IDX_PAL_DATA: v[31:0] = 32'h0000_0000;
      `BLTR_IDX_ALPHA: v[4:0] = alpha_q;
      `BLTR_IDX_FG: v[23:0] = fg_q;
      `BLTR_IDX_BG: v[23:0] = bg_q;
      default: v[32] = 1'b0;
    endcase
    return v;
  endfunction

  assign rd_view = reg_view(ar_idx);
  assign wr_view = reg_view(aw_idx_q);
  assign rd_word = rd_view[31:0];
  assign rd_mapped = rd_view[32] && s_axi_araddr[11:10] == 2'h0;
  assign old_word = wr_view[31:0];
  assign wr_mapped = wr_view[32];
  assign wr_word = merge(old_word, wdata_q, wstrb_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bad_wr_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[11:10] == 2'h0 ? s_axi_awaddr[9:2] : 8'hFF;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bad_wr_q <= !wr_mapped;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mapped ? rd_word : 32'h0000_0000;
      rresp_q <= rd_mapped ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration may change mid-run; the engine latches op and logic at start
  always_ff @(posedge clk) begin
    if (srst) begin
      oplog_q <= `BLTR_RST_OPLOG;
      ctrl0_q <= 8'h00;
      {a_base_q, b_base_q, d_base_q, fg_q, bg_q} <= '0;
      {a_width_q, b_width_q, d_width_q} <= '0;
      win_w_q <= `BLTR_RST_WIN;
      win_h_q <= `BLTR_RST_WIN;
      alpha_q <= `BLTR_RST_ALPHA;
    end else if (wr_fire) begin
      unique case (aw_idx_q)
        `BLTR_IDX_CTRL0: ctrl0_q <= {1'b0, wr_word[6:0]};
        `BLTR_IDX_OPLOG: oplog_q <= wr_word[7:0];
        `BLTR_IDX_A_BASE: a_base_q <= wr_word[23:0];
        `BLTR_IDX_A_WIDTH: a_width_q <= wr_word[11:0];
        `BLTR_IDX_B_BASE: b_base_q <= wr_word[23:0];
        `BLTR_IDX_B_WIDTH: b_width_q <= wr_word[11:0];
        `BLTR_IDX_D_BASE: d_base_q <= wr_word[23:0];
        `BLTR_IDX_D_WIDTH: d_width_q <= wr_word[11:0];
        `BLTR_IDX_WIN_W: win_w_q <= wr_word[11:0];
        `BLTR_IDX_WIN_H: win_h_q <= wr_word[11:0];
        `BLTR_IDX_ALPHA: alpha_q <= wr_word[4:0];
        `BLTR_IDX_FG: fg_q <= wr_word[23:0];
        `BLTR_IDX_BG: bg_q <= wr_word[23:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Engine datapath
  // ----------------------------------------
  logic [3:0] run_op_q, run_lf_q, bit_idx_q;
  logic [11:0] x_q, y_q;
  logic pend_q, have_word_q, mem_rd_q, mem_wr_q;
  logic [15:0] word_q;
  logic [23:0] a_q, b_q, addr_q, wdata_o_q, a_pix, a_src, result, logic_out, blend_out;
  logic [11:0] pal_entry;
  bltr_flags_t fl, start_fl;
  logic a_imm, last_pix, skip, exp_bit;
  logic [23:0] addr_a, addr_b, addr_d;

  assign fl = op_flags(run_op_q);
  assign start_fl = op_flags(oplog_q[3:0]);
  assign exp_bit = word_q[bit_idx_q];
  assign a_imm = fl.fill || (fl.exp && have_word_q);
  assign host_ready = state_q == ST_GET_A && fl.host && !a_imm;
  assign addr_a = fl.pat ? a_base_q + {18'h0, y_q[2:0], x_q[2:0]} : a_base_q + 24'(y_q * a_width_q) + {12'h0, x_q};
  assign addr_b = b_base_q + 24'(y_q * b_width_q) + {12'h0, x_q};
  assign addr_d = d_base_q + 24'(y_q * d_width_q) + {12'h0, x_q};
  assign a_pix = fl.fill ? fg_q : fl.exp ? (exp_bit ? fg_q : bg_q) : a_q;
  assign a_src = ctrl0_q[`BLTR_CTRL0_PALMODE] ? {{2{pal_entry[11:8]}}, {2{pal_entry[7:4]}}, {2{pal_entry[3:0]}}} : a_q;
  assign skip = fl.key && a_pix == bg_q;
  assign result = fl.lfn ? logic_out : fl.blend ? blend_out : a_pix;
  assign last_pix = x_q == win_w_q - 12'h001 && y_q == win_h_q - 12'h001;
  assign mem_addr = addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = wdata_o_q;

  bltr_pix_combine u_combine (
    .logic_code(run_lf_q),
    .alpha(alpha_q),
    .src_a(fl.blend ? a_src : a_pix),
    .src_b(b_q),
    .logic_out(logic_out),
    .blend_out(blend_out)
  );

  bltr_palette u_palette (
    .clk(clk),
    .srst(srst),
    .byte_we(pal_we),
    .byte_data(wdata_q[7:0]),
    .rd_index(a_q[5:0]),
    .rd_entry(pal_entry)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      {run_op_q, run_lf_q, bit_idx_q} <= '0;
      {x_q, y_q, word_q, a_q, b_q, addr_q, wdata_o_q} <= '0;
      {pend_q, have_word_q, mem_rd_q, mem_wr_q, int_flag_q} <= '0;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      // Write-one clears; a completion in the same cycle wins
      if (wr_fire && aw_idx_q == `BLTR_IDX_INTSRC && wstrb_q[0] && wdata_q[`BLTR_INTSRC_DONE]) begin
        int_flag_q <= 1'b0;
      end
      unique case (state_q)
        ST_IDLE: if (start_w) begin
          run_op_q <= oplog_q[3:0];
          run_lf_q <= oplog_q[7:4];
          {x_q, y_q, pend_q, have_word_q} <= '0;
          state_q <= start_fl.rsv ? ST_DONE : ST_GET_A;
        end
        ST_GET_A: if (a_imm) begin
          state_q <= fl.lfn || fl.blend ? ST_GET_B : ST_PUT;
        end else if (fl.host ? host_valid : pend_q) begin
          pend_q <= 1'b0;
          if (fl.exp) begin
            word_q <= fl.host ? host_data : mem_rdata[15:0];
            have_word_q <= 1'b1;
            // 8-bit port: start bits above 7 are invalid, only the low three bits count
            bit_idx_q <= host_port_16bit ? run_lf_q : {1'b0, run_lf_q[2:0]};
          end else begin
            a_q <= fl.host ? {8'h00, host_data} : mem_rdata;
            state_q <= fl.lfn || fl.blend ? ST_GET_B : ST_PUT;
          end
        end else if (!fl.host) begin
          mem_rd_q <= 1'b1;
          addr_q <= addr_a;
          pend_q <= 1'b1;
        end
        ST_GET_B: if (pend_q) begin
          pend_q <= 1'b0;
          b_q <= mem_rdata;
          state_q <= ST_PUT;
        end else begin
          mem_rd_q <= 1'b1;
          addr_q <= addr_b;
          pend_q <= 1'b1;
        end
        ST_PUT: begin
          if (!skip) begin
            mem_wr_q <= 1'b1;
            addr_q <= addr_d;
            wdata_o_q <= result;
          end
          if (fl.exp) begin
            have_word_q <= bit_idx_q != 4'h0;
            bit_idx_q <= bit_idx_q - 4'h1;
          end
          x_q <= x_q == win_w_q - 12'h001 ? 12'h000 : x_q + 12'h001;
          y_q <= x_q == win_w_q - 12'h001 ? y_q + 12'h001 : y_q;
          state_q <= last_pix ? ST_DONE : ST_GET_A;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
          int_flag_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_busy_hold;
    @(posedge clk) disable iff (srst) busy && state_q != ST_DONE |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_start_busy;
    @(posedge clk) disable iff (srst) start_w |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy");
  property p_int_on_clear;
    @(posedge clk) disable iff (srst) $fell(busy) |-> int_flag_q && !int_n;
  endproperty
  a_int_on_clear: assert property (p_int_on_clear) else $error("no interrupt at completion");
  property p_rsv_nowrite;
    @(posedge clk) disable iff (srst) start_w && start_fl.rsv |=> !mem_wr [*3];
  endproperty
  a_rsv_nowrite: assert property (p_rsv_nowrite) else $error("reserved op wrote memory");
  property p_fill_color;
    @(posedge clk) disable iff (srst) state_q == ST_PUT && fl.fill && !skip |=> mem_wr && mem_wdata == fg_q;
  endproperty
  a_fill_color: assert property (p_fill_color) else $error("fill colour wrong");
  property p_key_skip;
    @(posedge clk) disable iff (srst) state_q == ST_PUT && skip |=> !mem_wr;
  endproperty
  a_key_skip: assert property (p_key_skip) else $error("keyed pixel written");
  property p_logic_a;
    @(posedge clk) disable iff (srst) state_q == ST_PUT && fl.lfn && run_lf_q == 4'hC |=> mem_wdata == $past(a_pix);
  endproperty
  a_logic_a: assert property (p_logic_a) else $error("logic A pass wrong");
  property p_exp_fg;
    @(posedge clk) disable iff (srst) state_q == ST_PUT && fl.exp && exp_bit && !fl.key |=> mem_wdata == fg_q;
  endproperty
  a_exp_fg: assert property (p_exp_fg) else $error("expansion one not foreground");
  property p_pal_noread;
    @(posedge clk) disable iff (srst) rd_fire && ar_idx == `BLTR_IDX_PAL_DATA |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_pal_noread: assert property (p_pal_noread) else $error("palette readable");
  property p_busy_view;
    @(posedge clk) disable iff (srst) rd_fire && ar_idx == `BLTR_IDX_STATUS |=> s_axi_rdata[3] == $past(busy);
  endproperty
  a_busy_view: assert property (p_busy_view) else $error("status busy wrong");
  c_fill_done: cover property (@(posedge clk) disable iff (srst) fl.fill ##1 $fell(busy));
  c_key_skip: cover property (@(posedge clk) disable iff (srst) state_q == ST_PUT && skip);
  c_exp_run: cover property (@(posedge clk) disable iff (srst) state_q == ST_PUT && fl.exp && !exp_bit);
endmodule // bltr_engine

/* bench/bltr_mem_model.sv */
// Display memory model on the far side of the engine's memory port
module bltr_mem_model (
  input wire logic clk,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  output logic [23:0] mem_rdata,
  input wire logic mem_wr,
  input wire logic [23:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] mem [0:255];
  logic [23:0] junk_q = 24'h000000;
  int wr_cnt = 0;
  // Data stands only while the strobe is up; elsewhere it toggles so a late capture shows
  assign mem_rdata = mem_rd ? mem[mem_addr[7:0]] : junk_q;
  always @(posedge clk) begin
    junk_q <= ~junk_q;
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule // bltr_mem_model

/* bench/tb.sv */
// Self-checking bench of the block transfer engine
`include "bltr_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic host_port_16bit = 1'b1, host_valid = 1'b0;
  logic [15:0] host_data = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, host_ready, mem_rd, mem_wr, int_n;
  logic [1:0] bresp, rresp, last_bresp, r;
  logic [31:0] rdata, d;
  logic [23:0] mem_addr, mem_rdata, mem_wdata;
  logic [15:0] hq[$];
  logic [23:0] va = 24'hF0F0CC, vb = 24'hFF00AA, fg = 24'h123456, bg = 24'h0000AB;
  int error_cnt = 0;
  int tests_run = 0;
  int n0;
  logic [7:0] c0 = 8'h80;

  bltr_engine i_bltr_engine (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_port_16bit(host_port_16bit),
    .host_data(host_data), .host_valid(host_valid), .host_ready(host_ready), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .int_n(int_n));
  bltr_mem_model i_bltr_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata));

  always #50 clk = ~clk;

  // Host word source; idle data toggles so a stale capture is caught
  always @(posedge clk) begin
    if (host_valid && host_ready) begin
      void'(hq.pop_front());
    end
    host_valid <= (hq.size() != 0);
    host_data <= (hq.size() != 0) ? hq[0] : ~host_data;
  end

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [23:0] lfn_ref(input logic [3:0] lg, input logic [23:0] a, input logic [23:0] b);
    return ({24{lg[3]}} & a & b) | ({24{lg[2]}} & a & ~b) | ({24{lg[1]}} & ~a & b) | ({24{lg[0]}} & ~a & ~b);
  endfunction

  // Every call raises response ready again and no call lowers it, so it stays up between calls
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] dat);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    last_bresp = bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] dat);
    axi_wr(ba(idx), dat);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] dat;
    logic [1:0] resp;
    axi_rd(ba(idx), dat, resp);
    chk(dat & mask, exp);
  endtask

  // Start, optionally poll busy mid-run, wait for completion, then acknowledge it
  task automatic run(input logic [3:0] op, input logic [3:0] lg, input logic busy_chk);
    int n;
    n = 0;
    wr(`BLTR_IDX_OPLOG, {24'h000000, lg, op});
    wr(`BLTR_IDX_CTRL0, {24'h000000, c0});
    if (busy_chk) begin
      rd_chk(`BLTR_IDX_STATUS, 32'h8, 32'h8);
      rd_chk(`BLTR_IDX_CTRL0, 32'h10, 32'h10);
      chk(32'(int_n), 32'h1);
    end
    while (int_n !== 1'b0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(32'(int_n), 32'h0);
    rd_chk(`BLTR_IDX_STATUS, 32'h8, 32'h0);
    rd_chk(`BLTR_IDX_CTRL0, 32'h10, 32'h0);
    rd_chk(`BLTR_IDX_INTSRC, 32'h1, 32'h1);
    wr(`BLTR_IDX_INTSRC, 32'h1);
    rd_chk(`BLTR_IDX_INTSRC, 32'h1, 32'h0);
    chk(32'(int_n), 32'h1);
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) i_bltr_mem_model.mem[i] = 24'h000000;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd_chk(`BLTR_IDX_OPLOG, 32'hFF, 32'h00);
    rd_chk(`BLTR_IDX_WIN_H, 32'hFFF, 32'h001);
    rd_chk(`BLTR_IDX_ALPHA, 32'h1F, 32'h10);
    rd_chk(`BLTR_IDX_STATUS, 32'h8, 32'h0);
    chk(32'(int_n), 32'h1);
    axi_rd(12'hC00, d, r);
    chk(32'(r), 32'h2);
    axi_wr(12'hC04, 32'h1);
    chk(32'(last_bresp), 32'h2);
    // Fill of 3x2 inside a row pitch of 8; column 3 must stay untouched
    wr(`BLTR_IDX_FG, fg);
    wr(`BLTR_IDX_BG, bg);
    wr(`BLTR_IDX_D_BASE, 32'h10);
    wr(`BLTR_IDX_D_WIDTH, 32'h8);
    wr(`BLTR_IDX_WIN_W, 32'h3);
    wr(`BLTR_IDX_WIN_H, 32'h2);
    run(4'hC, 4'h5, 1'b1);
    for (int i = 0; i < 8; i++) chk(i_bltr_mem_model.mem[16 + (i / 4) * 8 + i % 4], (i % 4 < 3) ? fg : 0);
    wr(`BLTR_IDX_WIN_W, 32'h1);
    wr(`BLTR_IDX_WIN_H, 32'h1);
    wr(`BLTR_IDX_A_BASE, 32'h40);
    wr(`BLTR_IDX_B_BASE, 32'h41);
    wr(`BLTR_IDX_D_BASE, 32'h42);
    i_bltr_mem_model.mem[8'h40] = va;
    i_bltr_mem_model.mem[8'h41] = vb;
    for (int lg = 0; lg < 16; lg++) begin
      run(4'h2, lg[3:0], 1'b0);
      chk(i_bltr_mem_model.mem[8'h42], lfn_ref(lg[3:0], va, vb));
    end
    for (int op = 6; op < 8; op++) begin
      i_bltr_mem_model.mem[8'h42] = 24'h777777;
      run(op[3:0], 4'h0, 1'b0);
      chk(i_bltr_mem_model.mem[8'h42], op == 6 ? 24'h000000 : va);
    end
    for (int al = 0; al <= 16; al += 16) begin
      wr(`BLTR_IDX_ALPHA, al);
      run(4'hA, 4'h0, 1'b0);
      chk(i_bltr_mem_model.mem[8'h42], al ? va : vb);
    end
    // Host traffic: the middle keyed word equals the key and is skipped
    wr(`BLTR_IDX_D_BASE, 32'h50);
    wr(`BLTR_IDX_WIN_W, 32'h3);
    for (int i = 0; i < 3; i++) i_bltr_mem_model.mem[8'h50 + i] = 24'h777777;
    hq = '{16'h1111, 16'h00AB, 16'h2222};
    run(4'h4, 4'h0, 1'b0);
    chk(i_bltr_mem_model.mem[8'h50], 24'h001111);
    chk(i_bltr_mem_model.mem[8'h51], 24'h777777);
    chk(i_bltr_mem_model.mem[8'h52], 24'h002222);
    wr(`BLTR_IDX_WIN_W, 32'h1);
    hq.push_back(16'h1234);
    run(4'h0, 4'h6, 1'b0);
    chk(i_bltr_mem_model.mem[8'h50], 24'h001234 ^ vb);
    // Expansion from bit 3; code 11 on the narrow port keeps only its low bits
    wr(`BLTR_IDX_WIN_W, 32'h4);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) i_bltr_mem_model.mem[8'h50 + i] = 24'h000000;
      host_port_16bit <= ~k[0];
      hq.push_back(16'hFFFA);
      run(k[1] ? 4'h9 : 4'h8, k[0] ? 4'hB : 4'h3, 1'b0);
      for (int i = 0; i < 4; i++) chk(i_bltr_mem_model.mem[8'h50 + i], ((4'hA >> (3 - i)) & 1) ? fg : (k[1] ? 0 : bg));
    end
    // Expansion from memory: low word of the A pixel, from bit 3 down
    run(4'hE, 4'h3, 1'b0);
    for (int i = 0; i < 4; i++) chk(i_bltr_mem_model.mem[8'h50 + i], (i < 2) ? fg : bg);
    for (int op = 1; op < 14; op += (op == 3) ? 10 : 2) begin
      n0 = i_bltr_mem_model.wr_cnt;
      run(op[3:0], 4'h0, 1'b0);
      chk(i_bltr_mem_model.wr_cnt, n0);
    end
    for (int i = 0; i < 128; i++) wr(`BLTR_IDX_PAL_DATA, i);
    rd_chk(`BLTR_IDX_PAL_DATA, 32'hFFFFFFFF, 32'h0);
    // Palette blend at full opacity: index 12 holds nibble 8 and byte 19h
    wr(`BLTR_IDX_WIN_W, 32'h1);
    c0 = 8'h81;
    run(4'hA, 4'h0, 1'b0);
    chk(i_bltr_mem_model.mem[8'h50], 24'h881199);
    tally_and_finish;
  end

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule // tb
